// >>> core/rfg_detect.sv
// Counts back-to-back signal-strength samples above the detect level
`timescale 1ns/1ps
module rfg_detect
  import rfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clear,
  input wire logic sample_valid,
  input wire logic [LEVEL_W-1:0] signal_strength_sample,
  input wire logic [LEVEL_W-1:0] signal_detect_level,
  output logic hit
);

  typedef struct packed {
    logic [1:0] run;
  } rfg_det_state_t;

  rfg_det_state_t s;
  rfg_det_state_t next_s;

  // Run length of qualifying samples, saturating at the target
  always_comb
  begin
    next_s = s;
    if (clear)
    begin
      next_s.run = 2'h0;
    end
    else if (sample_valid)
    begin
      if (signal_strength_sample > signal_detect_level)
      begin
        if (s.run != DETECT_RUN)
        begin
          next_s.run = s.run + 2'h1;
        end
      end
      else
      begin
        next_s.run = 2'h0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else if (ce)
    begin
      s <= next_s;
    end
  end

  assign hit = (s.run == DETECT_RUN);

endmodule

// >>> core/rfg_dev.sv
// Device end: front-amplifier gain selection and automatic gain loop
//
// Added by the designer: register access over Wishbone and the address map.
`timescale 1ns/1ps
module rfg_dev
  import rfg_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CE,
  rfg_link_if.dev LINK,
  input wire logic RX_ENABLE,
  input wire logic SAMPLE_VALID,
  input wire logic [LEVEL_W-1:0] SIGNAL_STRENGTH_SAMPLE,
  output logic [GAIN_W-1:0] FRONT_AMP_GAIN,
  output logic WAITING
);

  typedef struct packed {
    rfg_agc_st_t st;
    logic [GAIN_W-1:0] gain;
    logic [HOLD_CNT_W-1:0] hold_cnt;
    logic waiting;
  } rfg_dev_state_t;

  rfg_dev_state_t s;
  rfg_dev_state_t next_s;
  logic det_hit;
  logic det_clear;
  logic auto_mode;

  // Automatic loop runs only with the default gain code
  assign auto_mode = (LINK.gain_code == GAIN_AUTO);

  // Detector restarts whenever we are not actually waiting
  assign det_clear = (s.st != ST_WAIT) || !RX_ENABLE || !auto_mode || LINK.rearm_request;

  rfg_detect rfg_detect_i (
    .clk(CORE_CLK),
    .rst(RST),
    .ce(CE),
    .clear(det_clear),
    .sample_valid(SAMPLE_VALID),
    .signal_strength_sample(SIGNAL_STRENGTH_SAMPLE),
    .signal_detect_level(LINK.signal_detect_level),
    .hit(det_hit)
  );

  // Stronger signals get lower gain: step down once per crossed threshold.
  // Margin is measured above the detect level, so it tracks host tuning.
  function automatic logic [GAIN_W-1:0] pick_gain(
    input logic [LEVEL_W-1:0] sample,
    input logic [LEVEL_W-1:0] level
  );
    logic [LEVEL_W-1:0] margin;
    logic [GAIN_W-1:0] g;
    margin = (sample > level) ? LEVEL_W'(sample - level) : '0;
    g = GAIN_STEP_MAX;
    for (int i = 0; i < $size(AGC_STEP_TH); i++)
    begin
      if (margin >= AGC_STEP_TH[i])
      begin
        g = GAIN_W'(GAIN_STEP_MAX + GAIN_W'(i + 1));
      end
    end
    pick_gain = g;
  endfunction

  // Gain-loop sequencing
  always_comb
  begin
    next_s = s;
    if (!RX_ENABLE)
    begin
      next_s.st = ST_IDLE;
      next_s.hold_cnt = '0;
    end
    else
    begin
      unique case (s.st)
        ST_IDLE:
        begin
          next_s.st = ST_WAIT;
        end
        ST_WAIT:
        begin
          if (det_hit && auto_mode)
          begin
            next_s.gain = pick_gain(SIGNAL_STRENGTH_SAMPLE, LINK.signal_detect_level);
            next_s.st = ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          // No rearm: gain carries into the next packet unchanged
          if (!LINK.cont_mode && LINK.auto_rearm_enable && LINK.fifo_drained)
          begin
            next_s.st = ST_HOLDOFF;
            next_s.hold_cnt = holdoff_cycles(LINK.rearm_holdoff_delay);
          end
        end
        ST_HOLDOFF:
        begin
          // Lets the far transmitter ramp down before we listen again
          if (s.hold_cnt == '0)
          begin
            next_s.st = ST_WAIT;
          end
          else
          begin
            next_s.hold_cnt = s.hold_cnt - HOLD_CNT_W'(1);
          end
        end
      endcase
      // Restart request overrides the next state and hold count in either transfer mode; a gain picked this cycle still loads
      if (LINK.rearm_request)
      begin
        next_s.st = ST_WAIT;
        next_s.hold_cnt = '0;
      end
    end
    // Fixed codes drive the amplifier directly; reserved code keeps last gain
    if (gain_is_fixed(LINK.gain_code))
    begin
      next_s.gain = LINK.gain_code;
    end
    next_s.waiting = (next_s.st == ST_WAIT) && auto_mode;
  end

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      s.st <= ST_IDLE;
      s.gain <= GAIN_STEP_MAX;
      s.hold_cnt <= '0;
      s.waiting <= 1'b0;
    end
    else if (CE)
    begin
      s <= next_s;
    end
  end

  // Applied gain is visible both to the amplifier and to the host
  assign FRONT_AMP_GAIN = s.gain;
  assign WAITING = s.waiting;
  assign LINK.applied_gain_readback = s.gain;
  assign LINK.waiting = s.waiting;

endmodule

// >>> core/rfg_host.sv
// Host end: Wishbone register slave that programs the gain controller
`timescale 1ns/1ps
module rfg_host
  import rfg_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CE,
  rfg_link_if.host LINK,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [WB_AW-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O
);

  typedef struct packed {
    logic [GAIN_W-1:0] gain_code;
    logic auto_rearm_enable;
    logic cont_mode;
    logic [LEVEL_W-1:0] level;
    logic [HOLDOFF_W-1:0] holdoff;
    logic rearm_request;
    logic fifo_drained;
    logic ack;
    logic [31:0] dat;
  } rfg_host_state_t;

  rfg_host_state_t s;
  rfg_host_state_t next_s;
  logic req;

  // One access per request; ack drops the cycle after it rose
  assign req = WB_CYC_I && WB_STB_I && !s.ack;

  always_comb
  begin
    next_s = s;
    next_s.ack = req;
    next_s.rearm_request = 1'b0;
    next_s.fifo_drained = 1'b0;
    if (req && WB_WE_I)
    begin
      unique case (WB_ADR_I)
        REG_CTRL:
        begin
          if (WB_SEL_I[0])
          begin
            next_s.gain_code = WB_DAT_I[CTRL_GAIN_LSB +: GAIN_W];
            next_s.auto_rearm_enable = WB_DAT_I[CTRL_REARM_EN_BIT];
            next_s.cont_mode = WB_DAT_I[CTRL_CONT_BIT];
          end
          if (WB_SEL_I[1])
          begin
            // Write-one strobes; they read back as zero
            next_s.rearm_request = WB_DAT_I[CTRL_RESTART_BIT];
            next_s.fifo_drained = WB_DAT_I[CTRL_DRAINED_BIT];
          end
        end
        REG_LEVEL:
        begin
          if (WB_SEL_I[0])
          begin
            next_s.level = WB_DAT_I[LEVEL_LSB +: LEVEL_W];
          end
          if (WB_SEL_I[1])
          begin
            next_s.holdoff = WB_DAT_I[HOLDOFF_LSB +: HOLDOFF_W];
          end
        end
        default:
        begin
        end
      endcase
    end
    // Read data registered with the ack; unmapped reads return zero
    next_s.dat = '0;
    if (req && !WB_WE_I)
    begin
      unique case (WB_ADR_I)
        REG_CTRL:
        begin
          next_s.dat[CTRL_GAIN_LSB +: GAIN_W] = s.gain_code;
          next_s.dat[CTRL_REARM_EN_BIT] = s.auto_rearm_enable;
          next_s.dat[CTRL_CONT_BIT] = s.cont_mode;
        end
        REG_LEVEL:
        begin
          next_s.dat[LEVEL_LSB +: LEVEL_W] = s.level;
          next_s.dat[HOLDOFF_LSB +: HOLDOFF_W] = s.holdoff;
        end
        REG_STATUS:
        begin
          next_s.dat[STAT_GAIN_LSB +: GAIN_W] = LINK.applied_gain_readback;
          next_s.dat[STAT_WAIT_BIT] = LINK.waiting;
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      s <= '0;
      s.gain_code <= GAIN_AUTO;
      s.level <= LEVEL_RST;
      s.holdoff <= HOLDOFF_RST;
    end
    else if (CE)
    begin
      s <= next_s;
    end
  end

  assign WB_ACK_O = s.ack;
  assign WB_DAT_O = s.dat;
  assign LINK.gain_code = s.gain_code;
  assign LINK.signal_detect_level = s.level;
  assign LINK.rearm_holdoff_delay = s.holdoff;
  assign LINK.auto_rearm_enable = s.auto_rearm_enable;
  assign LINK.cont_mode = s.cont_mode;
  assign LINK.rearm_request = s.rearm_request;
  assign LINK.fifo_drained = s.fifo_drained;

endmodule

// >>> core/rfg_link_if.sv
// Link between the gain-control host end and the device end
`timescale 1ns/1ps
interface rfg_link_if;
  import rfg_pkg::*;
  logic [GAIN_W-1:0] gain_code;
  logic [LEVEL_W-1:0] signal_detect_level;
  logic [HOLDOFF_W-1:0] rearm_holdoff_delay;
  logic auto_rearm_enable;
  logic cont_mode;
  logic rearm_request;
  logic fifo_drained;
  logic [GAIN_W-1:0] applied_gain_readback;
  logic waiting;

  modport dev (
    input gain_code,
    input signal_detect_level,
    input rearm_holdoff_delay,
    input auto_rearm_enable,
    input cont_mode,
    input rearm_request,
    input fifo_drained,
    output applied_gain_readback,
    output waiting
  );

  modport host (
    output gain_code,
    output signal_detect_level,
    output rearm_holdoff_delay,
    output auto_rearm_enable,
    output cont_mode,
    output rearm_request,
    output fifo_drained,
    input applied_gain_readback,
    input waiting
  );
endinterface

// >>> core/rfg_pkg.sv
// Shared constants, types and helpers for the front-amplifier gain control
package rfg_pkg;

  localparam int GAIN_W = 3;
  localparam int LEVEL_W = 8;
  localparam int HOLDOFF_W = 8;
  localparam int HOLD_CNT_W = 12;

  // Gain code encodings
  localparam logic [GAIN_W-1:0] GAIN_AUTO = 3'h0;
  localparam logic [GAIN_W-1:0] GAIN_STEP_MAX = 3'h1;
  localparam logic [GAIN_W-1:0] GAIN_STEP_MIN = 3'h6;
  localparam logic [GAIN_W-1:0] GAIN_RSVD = 3'h7;

  // Consecutive qualifying samples needed to leave the wait state
  localparam logic [1:0] DETECT_RUN = 2'h2;

  // Signal margins above the detect level at which the loop steps gain down
  localparam logic [4:0][LEVEL_W-1:0] AGC_STEP_TH = {8'h50, 8'h3C, 8'h28, 8'h14, 8'h0A};

  // Holdoff time base: one holdoff unit is 1 us
  localparam int CLK_PERIOD_NS = 100;
  localparam int HOLDOFF_UNIT_NS = 1000;
  localparam int HOLDOFF_UNIT_CYC_I = (HOLDOFF_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [HOLD_CNT_W-1:0] HOLDOFF_UNIT_CYC = HOLD_CNT_W'(HOLDOFF_UNIT_CYC_I);

  // Wishbone register map (byte addresses, word aligned)
  localparam int WB_AW = 4;
  localparam logic [WB_AW-1:0] REG_CTRL = 4'h0;
  localparam logic [WB_AW-1:0] REG_LEVEL = 4'h4;
  localparam logic [WB_AW-1:0] REG_STATUS = 4'h8;

  // CTRL fields
  localparam int CTRL_GAIN_LSB = 0;
  localparam int CTRL_REARM_EN_BIT = 3;
  localparam int CTRL_CONT_BIT = 4;
  localparam int CTRL_RESTART_BIT = 8;
  localparam int CTRL_DRAINED_BIT = 9;
  // LEVEL fields
  localparam int LEVEL_LSB = 0;
  localparam int HOLDOFF_LSB = 8;
  // STATUS fields
  localparam int STAT_GAIN_LSB = 0;
  localparam int STAT_WAIT_BIT = 4;

  // Reset values
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 8'hE4;
  localparam logic [HOLDOFF_W-1:0] HOLDOFF_RST = 8'h00;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_HOLD, ST_HOLDOFF} rfg_agc_st_t;

  // Fixed step codes are 1..6; auto and reserved are not
  function automatic logic gain_is_fixed(input logic [GAIN_W-1:0] code);
    gain_is_fixed = (code >= GAIN_STEP_MAX) && (code <= GAIN_STEP_MIN);
  endfunction

  // Holdoff setting in units converted to clock cycles
  function automatic logic [HOLD_CNT_W-1:0] holdoff_cycles(input logic [HOLDOFF_W-1:0] units);
    logic [2*HOLD_CNT_W-1:0] prod;
    prod = {{(2*HOLD_CNT_W-HOLDOFF_W){1'b0}}, units} * {{HOLD_CNT_W{1'b0}}, HOLDOFF_UNIT_CYC};
    holdoff_cycles = prod[HOLD_CNT_W-1:0];
  endfunction

endpackage

// >>> tb/rfg_link_sva.sv
// Checker for the gain control link between the host and device ends
`timescale 1ns/1ps
module rfg_link_sva
  import rfg_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic RX_ENABLE,
  input wire logic SAMPLE_VALID,
  input wire logic [LEVEL_W-1:0] SIGNAL_STRENGTH_SAMPLE,
  input wire logic [GAIN_W-1:0] gain_code,
  input wire logic [LEVEL_W-1:0] signal_detect_level,
  input wire logic [HOLDOFF_W-1:0] rearm_holdoff_delay,
  input wire logic auto_rearm_enable,
  input wire logic cont_mode,
  input wire logic rearm_request,
  input wire logic fifo_drained,
  input wire logic [GAIN_W-1:0] applied_gain_readback,
  input wire logic waiting
);
  logic q;
  logic au;
  // Equal to the level does not qualify; restart strobes excluded from auto
  assign q = SAMPLE_VALID && (SIGNAL_STRENGTH_SAMPLE > signal_detect_level);
  assign au = RX_ENABLE && (gain_code == 3'h0) && !rearm_request;

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  // Gain rules, then wait-state rules
  a_fixed_gain_follows: assert property ((gain_code inside {[3'h1:3'h6]}) |=>
    applied_gain_readback == $past(gain_code)) else $error("fixed gain not applied");
  a_fixed_no_wait: assert property ((gain_code inside {[3'h1:3'h6]}) |=> !waiting)
    else $error("wait state in fixed gain");
  a_rsvd_keeps_gain: assert property (gain_code == 3'h7 && $past(gain_code) == 3'h7 |->
    $stable(applied_gain_readback)) else $error("reserved code moved gain");
  a_gain_in_range: assert property (applied_gain_readback inside {[3'h1:3'h6]})
    else $error("applied gain outside steps");
  a_two_end_wait: assert property (au && waiting && q ##1 au && q |=> ##[0:2] !waiting)
    else $error("wait not left after two samples");
  a_fail_clears_run: assert property (au && waiting && SAMPLE_VALID && !q ##1 au && waiting && q ##1 au
    && SAMPLE_VALID && !q |=> waiting) else $error("run not cleared by failing sample");
  a_gain_held: assert property (au && $past(au) && !waiting && !$past(waiting) |->
    $stable(applied_gain_readback)) else $error("gain changed while held");
  a_no_rearm_stays: assert property (au && !cont_mode && !auto_rearm_enable && fifo_drained && !waiting
    |=> !waiting [*4]) else $error("rearmed while disabled");
  a_rearm_holdoff: assert property (au && !cont_mode && auto_rearm_enable && fifo_drained && !waiting
    && (rearm_holdoff_delay inside {[8'h01:8'h50]}) |=> !waiting [*8] ##[1:1000] waiting)
    else $error("rearm holdoff wrong");
  a_restart_packet: assert property (RX_ENABLE && gain_code == 3'h0 && rearm_request && !cont_mode
    |=> waiting) else $error("packet restart ignored");
  a_restart_cont: assert property (RX_ENABLE && gain_code == 3'h0 && rearm_request && cont_mode
    |=> waiting) else $error("continuous restart ignored");
endmodule

// >>> tb/rx_front_gain_agc_control_test.sv
// Self-checking bench joining the host and device ends of the gain control
`timescale 1ns/1ps
module rx_front_gain_agc_control_test;
  import rfg_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rx = 1'b0;
  logic [7:0] smp = 8'h00;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic ack;
  logic [2:0] amp;
  logic [31:0] rd_q;
  logic wt;
  logic vld = 1'b1;
  int num_errors = 0;
  int n_checks = 0;

  rfg_link_if link();
  rfg_host rfg_host_i (.CORE_CLK(clk), .RST(rst), .CE(1'b1), .LINK(link), .WB_CYC_I(stb), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h3), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack));
  rfg_dev rfg_dev_i (.CORE_CLK(clk), .RST(rst), .CE(1'b1), .LINK(link), .RX_ENABLE(rx), .SAMPLE_VALID(vld),
    .SIGNAL_STRENGTH_SAMPLE(smp), .FRONT_AMP_GAIN(amp), .WAITING(wt));
  rfg_link_sva rfg_link_sva_i (.CORE_CLK(clk), .RST(rst), .RX_ENABLE(rx), .SAMPLE_VALID(vld),
    .SIGNAL_STRENGTH_SAMPLE(smp), .gain_code(link.gain_code), .signal_detect_level(link.signal_detect_level),
    .rearm_holdoff_delay(link.rearm_holdoff_delay), .auto_rearm_enable(link.auto_rearm_enable),
    .cont_mode(link.cont_mode), .rearm_request(link.rearm_request), .fifo_drained(link.fifo_drained),
    .applied_gain_readback(link.applied_gain_readback), .waiting(link.waiting));

  // 10 MHz core clock
  always #50 clk = ~clk;

  task conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // One classic cycle; request held until ack is sampled high, only the watchdog ends a hang
  task xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    rd_q = dat_o;
    stb <= 1'b0;
  endtask

  task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd_q & m, e);
  endtask

  // Sample stream held for n cycles
  task feed(input logic [7:0] s, input int n);
    smp <= s;
    repeat (n) @(posedge clk);
  endtask

  task t_reset();
    rd(REG_STATUS, 32'hFFFFFFFF, 32'h1);
    rd(REG_LEVEL, 32'hFFFFFFFF, 32'hE4);
    rd(4'hC, 32'hFFFFFFFF, 32'h0);
  endtask

  // Every fixed step, then the reserved code which must keep the last one
  task t_fixed();
    rx <= 1'b1;
    for (int c = 1; c < 8; c++)
    begin
      xfer(1'b1, REG_CTRL, 32'(c));
      rd(REG_STATUS, 32'h1F, (c == 7) ? 32'h6 : 32'(c));
    end
  endtask

  // Margin 0x30 crosses three thresholds, so step 4
  task t_auto();
    rx <= 1'b0;
    xfer(1'b1, REG_LEVEL, 32'h20);
    xfer(1'b1, REG_CTRL, 32'h0);
    rx <= 1'b1;
    feed(8'h00, 2);
    rd(REG_STATUS, 32'h10, 32'h10);
    chk({31'h0, wt}, 32'h1);
    feed(8'h50, 1);
    feed(8'h20, 1);
    feed(8'h50, 1);
    feed(8'h20, 2);
    rd(REG_STATUS, 32'h10, 32'h10);
    feed(8'h50, 2);
    rd(REG_STATUS, 32'h1F, 32'h4);
    chk({29'h0, amp}, 32'h4);
    chk({31'h0, wt}, 32'h0);
  endtask

  task t_hold();
    feed(8'hFF, 2);
    rd(REG_STATUS, 32'h1F, 32'h4);
    xfer(1'b1, REG_CTRL, 32'h200);
    feed(8'h00, 8);
    rd(REG_STATUS, 32'h1F, 32'h4);
  endtask

  // Holdoff of 2 units is 20 cycles: still holding off near cycle 18, waiting by cycle 33
  task t_rearm();
    xfer(1'b1, REG_LEVEL, 32'h220);
    xfer(1'b1, REG_CTRL, 32'h208);
    rd(REG_STATUS, 32'h10, 32'h0);
    feed(8'h00, 12);
    rd(REG_STATUS, 32'h10, 32'h0);
    feed(8'h00, 12);
    rd(REG_STATUS, 32'h10, 32'h10);
  endtask

  // Restart in packet mode, then in continuous mode where drain is ignored
  task t_restart();
    feed(8'h7F, 4);
    rd(REG_STATUS, 32'h1F, 32'h6);
    feed(8'h00, 1);
    xfer(1'b1, REG_CTRL, 32'h100);
    rd(REG_STATUS, 32'h10, 32'h10);
    xfer(1'b1, REG_CTRL, 32'h10);
    feed(8'h7F, 4);
    rd(REG_STATUS, 32'h1F, 32'h6);
    xfer(1'b1, REG_CTRL, 32'h218);
    feed(8'h00, 8);
    rd(REG_STATUS, 32'h10, 32'h0);
    xfer(1'b1, REG_CTRL, 32'h110);
    rd(REG_STATUS, 32'h10, 32'h10);
  endtask

  // Strong samples flagged invalid must not end the wait; valid ones then do
  task t_invalid();
    vld <= 1'b0;
    feed(8'h7F, 4);
    rd(REG_STATUS, 32'h10, 32'h10);
    vld <= 1'b1;
    feed(8'h7F, 4);
    rd(REG_STATUS, 32'h1F, 32'h6);
  endtask

  // Main sequence after five reset cycles
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_fixed();
    t_auto();
    t_hold();
    t_rearm();
    t_restart();
    t_invalid();
    conclude();
  end

  // Run needs well under a thousand cycles
  initial
  begin
    #500us;
    num_errors++;
    conclude();
  end
endmodule
